// >>> hw/dpram_pkg.sv
// Package: timing constants and carriers for the dual-port RAM port controller
package dpram_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 9;

  // Minimum times in ns, fastest grade
  localparam int unsigned T_READ_CYCLE_NS   = 12;
  localparam int unsigned T_ADDR_ACCESS_NS  = 12;
  localparam int unsigned T_OE_ACCESS_NS    = 8;
  localparam int unsigned T_OUT_HIZ_NS      = 7;
  localparam int unsigned T_WRITE_PULSE_NS  = 10;
  localparam int unsigned T_ADDR_TO_WEND_NS = 10;
  localparam int unsigned T_SETUP_WEND_NS   = 8;
  localparam int unsigned T_WR_RECOVERY_NS  = 1;
  localparam int unsigned T_WRITE_HIZ_NS    = 7;

  // Least times round up to whole cycles, never below one
  function automatic int unsigned dp_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int unsigned dp_max(input int unsigned a, input int unsigned b);
    return (a > b) ? a : b;
  endfunction

  localparam int unsigned READ_CYC  = dp_cyc(dp_max(T_READ_CYCLE_NS, dp_max(T_ADDR_ACCESS_NS, T_OE_ACCESS_NS)));
  localparam int unsigned HIZ_CYC   = dp_cyc(T_OUT_HIZ_NS);
  localparam int unsigned WP_OE_HI  = dp_cyc(dp_max(T_WRITE_PULSE_NS, dp_max(T_ADDR_TO_WEND_NS, T_SETUP_WEND_NS)));
  localparam int unsigned WP_OE_LO  = dp_cyc(dp_max(WP_OE_HI * CLK_PERIOD_NS, T_WRITE_HIZ_NS + T_SETUP_WEND_NS));
  localparam int unsigned REC_CYC   = dp_cyc(T_WR_RECOVERY_NS);

  localparam logic [3:0] READ_CNT   = 4'(READ_CYC);
  localparam logic [3:0] HIZ_CNT    = 4'(HIZ_CYC);
  localparam logic [3:0] WP_HI_CNT  = 4'(WP_OE_HI);
  localparam logic [3:0] WP_LO_CNT  = 4'(WP_OE_LO);
  localparam logic [3:0] REC_CNT    = 4'(REC_CYC);
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;

  typedef enum { DP_IDLE, DP_RD, DP_WHIZ, DP_WPULSE, DP_WREC } dpram_state_e;

  typedef struct packed {
    logic              write;
    logic              keep_oe_low;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpram_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rw;
    logic              oe_n;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } dpram_pins_s;

endpackage

// >>> hw/dpram_port_ctrl.sv
// Module: host-side access controller for one port of the dual-port RAM
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1: Read/write select stays high whenever the address lines change.
// R2: Never drive write data while the memory may still drive the bus.
// R3: With output enable low, pulse lasts max of 10 ns and 7+8 ns.
// R4: With output enable high, write pulse may be just 10 ns.
// R5: Write data held at least 0 ns after the pulse ends.
// R6: Far-port read sees written data within 25 ns / 22 ns.
// R7: Both ports use identical timing; either may write.
// R8: Address is stable before output enable falls in a read.
// R9: Read data valid 8 ns after output enable falls.
// R10: Old data held 3 ns after address change.
// R11: Write address valid at least 10 ns before pulse ends.
// R12: Write data valid at least 8 ns before pulse ends.
// R13: Memory releases outputs within 7 ns after select falls.
// R14: Stop driving data when the pulse ends, bar the hold.
// R15: Select low writes, select high with enable low reads.
// R16: Never write one location from both ports at once.
// R17: Data word is nine bits, one usable as parity.
// R18: Every minimum interval counted in whole cycles, rounded up.
module dpram_port_ctrl
  import dpram_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                srst,
  // User request
  input  wire logic                req_valid,
  input  wire dpram_req_s          req,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [DATA_W-1:0]        rsp_data,
  // Memory port pins
  output logic [ADDR_W-1:0]        mem_addr,
  output logic                     mem_rw,
  output logic                     mem_oe_n,
  output logic [DATA_W-1:0]        mem_data_o,
  output logic                     mem_data_oe,
  input  wire logic [DATA_W-1:0]   mem_data_i
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dpram_state_e      st;
    logic [3:0]        cnt;
    logic              keep_lo;
    dpram_pins_s       pins;
    logic              ready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
  } dpram_ctl_s;

  dpram_ctl_s r;
  dpram_ctl_s next_r;

  // Least low-select span for the chosen enable level
  function automatic logic [3:0] wp_need(input logic lo);
    return lo ? WP_LO_CNT : WP_HI_CNT; // R7 R18
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    // Pin data passes two flops before use
    next_r.din_s1 = mem_data_i;
    next_r.din_s2 = r.din_s1;
    case (r.st)
      DP_IDLE: begin
        if (req_valid && r.ready) begin
          // Address moves only while select is high, in idle R1
          next_r.pins.addr = req.addr; // R1 R11
          next_r.ready     = 1'b0;
          if (req.write) begin
            // Enable waits for the select, so no read starts on a moving address
            next_r.keep_lo    = req.keep_oe_low;
            // No view of the far port: same-word writes are kept apart upstream
            next_r.pins.dout  = req.wdata; // R16
            next_r.st         = DP_WHIZ;
            next_r.cnt        = HIZ_CNT;
          end else begin
            // Address settles a cycle before enable falls R8
            next_r.pins.oe_n = 1'b1; // R8
            next_r.st        = DP_RD;
            next_r.cnt       = READ_CNT + CNT_ONE; // R18
          end
        end
      end
      DP_RD: begin
        next_r.pins.oe_n = 1'b0; // R15
        next_r.cnt       = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE) begin
          // Three extra cycles cover the two-flop sync; the pins stay put while data is sampled
          next_r.st  = DP_WREC;
          next_r.cnt = CNT_ONE + CNT_ONE + CNT_ONE;
        end
      end
      DP_WHIZ: begin
        if (r.pins.rw) begin
          // Select falls a cycle after the address, never with it
          next_r.pins.rw   = 1'b0; // R1 R13
          next_r.pins.oe_n = ~r.keep_lo;
          next_r.cnt       = HIZ_CNT;
        end else begin
          // Memory outputs turn off before we drive
          next_r.cnt = r.cnt - CNT_ONE;
          if (r.cnt <= CNT_ONE) begin
            next_r.st       = DP_WPULSE;
            next_r.pins.doe = 1'b1; // R2
            // Turn-off wait counts toward the pulse; one driven cycle covers set-up
            if (wp_need(r.keep_lo) > HIZ_CNT) begin
              next_r.cnt = wp_need(r.keep_lo) - HIZ_CNT; // R3 R4
            end else begin
              next_r.cnt = CNT_ONE; // R4 R12
            end
          end
        end
      end
      DP_WPULSE: begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt <= CNT_ONE) begin
          // Select rises and drive drops together: hold is 0 ns R5 R14
          next_r.pins.rw   = 1'b1; // R12
          next_r.pins.doe  = 1'b0; // R14
          // Enable parks high so recovery is never taken for a read
          next_r.pins.oe_n = 1'b1; // R14
          next_r.st       = DP_WREC;
          next_r.cnt      = REC_CNT;
        end
      end
      DP_WREC: begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt <= CNT_ONE) begin
          if (!r.pins.oe_n && r.pins.rw) begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = r.din_s2;
          end
          next_r.pins.oe_n = 1'b1;
          next_r.st        = DP_IDLE;
          next_r.ready     = 1'b1;
          next_r.cnt       = CNT_ZERO;
        end
      end
      default: next_r.st = DP_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r           <= '0;
      r.st        <= DP_IDLE;
      r.pins.rw   <= 1'b1;
      r.pins.oe_n <= 1'b1;
      r.ready     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign req_ready   = r.ready;
  assign rsp_valid   = r.rvalid;
  assign rsp_data    = r.rdata;
  assign mem_addr    = r.pins.addr;
  assign mem_rw      = r.pins.rw;
  assign mem_oe_n    = r.pins.oe_n;
  assign mem_data_o  = r.pins.dout;
  assign mem_data_oe = r.pins.doe;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_wr_start;
    $fell(mem_rw);
  endsequence

  // Select low, then still low with our data on the bus
  sequence s_pulse_body;
    !mem_rw ##1 (!mem_rw && mem_data_oe);
  endsequence

  sequence s_rd_start;
    $fell(mem_oe_n) && mem_rw;
  endsequence

  AST_ADDR_RW_HIGH: assert property (@(posedge core_clk) disable iff (srst) // R1
    !$stable(mem_addr) |-> mem_rw && $past(mem_rw)) else $error("address moved during write");
  AST_NO_DRIVE_ON_START: assert property (@(posedge core_clk) disable iff (srst) // R2
    s_wr_start |-> !mem_data_oe) else $error("data driven as write began");
  AST_PULSE_OE_LOW: assert property (@(posedge core_clk) disable iff (srst) // R3
    (s_wr_start ##0 !mem_oe_n) |-> !mem_rw [*2]) else $error("short write pulse, enable low");
  AST_PULSE_OE_HIGH: assert property (@(posedge core_clk) disable iff (srst) // R4
    (s_wr_start ##0 mem_oe_n) |-> s_pulse_body) else $error("short write pulse");
  AST_DRIVE_END: assert property (@(posedge core_clk) disable iff (srst) // R14
    $rose(mem_rw) |-> !mem_data_oe) else $error("data driven after pulse");
  AST_OE_AFTER_ADDR: assert property (@(posedge core_clk) disable iff (srst) // R8
    $fell(mem_oe_n) && mem_rw |-> $stable(mem_addr)) else $error("address unstable at enable");
  AST_SETUP: assert property (@(posedge core_clk) disable iff (srst) // R12
    $rose(mem_rw) |-> $past(mem_data_oe)) else $error("data setup missed");
  AST_READ_DONE: assert property (@(posedge core_clk) disable iff (srst) // R18
    $fell(mem_oe_n) && mem_rw |-> ##[2:6] rsp_valid) else $error("read not completed");
  AST_DRIVE_IN_PULSE: assert property (@(posedge core_clk) disable iff (srst) // R2
    mem_data_oe |-> !mem_rw && !$past(mem_rw)) else $error("data driven outside pulse");
  AST_ADDR_IN_PULSE: assert property (@(posedge core_clk) disable iff (srst) // R11
    !mem_rw |-> $stable(mem_addr)) else $error("address moved in pulse");
  AST_DATA_STEADY: assert property (@(posedge core_clk) disable iff (srst) // R12
    mem_data_oe |-> $stable(mem_data_o)) else $error("write data moved");
  AST_OE_PARK_WRITE: assert property (@(posedge core_clk) disable iff (srst) // R14
    $rose(mem_rw) |-> mem_oe_n) else $error("enable low after pulse");
  AST_IDLE_PARKED: assert property (@(posedge core_clk) disable iff (srst) // R1
    req_ready |-> mem_rw && mem_oe_n && !mem_data_oe) else $error("pins not parked in idle");
  AST_RD_ENABLE_LEN: assert property (@(posedge core_clk) disable iff (srst) // R18
    s_rd_start |-> !mem_oe_n [*4]) else $error("read enable too short");

endmodule

`default_nettype wire

// >>> bench/dpram_mem_model.sv
// Behavioural memory array behind one controller port
`timescale 1ns/10ps
`default_nettype none
module dpram_mem_model
  import dpram_pkg::*;
#(parameter int RD_NS = 8)
(
  // Pins from the controller
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              rw,
  input  wire logic              oe_n,
  input  wire logic              data_oe,
  input  wire logic [DATA_W-1:0] data_o,
  // Bus level and contention flag
  output logic      [DATA_W-1:0] data_i,
  output logic                   clash
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last = '0;
  logic              drv;
  assign drv = rw & ~oe_n;
  // Array takes the word at once, so a far-port read sees it well in time
  always @* if (!rw && data_oe) mem[addr] = data_o;
  always @* if (drv) last = mem[addr];
  // Old word lingers RD_NS, released bus shows its inverse
  assign #(RD_NS) data_i = data_oe ? data_o : (drv ? mem[addr] : ~last);
  assign clash = data_oe & drv;
endmodule
`default_nettype wire

// >>> bench/test_dpram_port_ctrl.sv
// Testbench: write and read-back traffic through one port controller
`timescale 1ns/10ps
`default_nettype none
module test_dpram_port_ctrl
  import dpram_pkg::*;
;
  logic              core_clk = 0, srst = 1, req_valid = 0;
  dpram_req_s        req = '0;
  logic              req_ready, rsp_valid, mem_rw, mem_oe_n, mem_data_oe, clash;
  logic [DATA_W-1:0] rsp_data, mem_data_o, mem_data_i;
  logic [ADDR_W-1:0] mem_addr, pa = '0;
  logic              prw = 1, po = 1, pdoe = 0, ol = 0;
  logic [3:0]        wl = '0;
  logic [DATA_W-1:0] expq[$];
  logic [31:0]       rng = 32'h0001350d;
  int                n_mismatch = 0, n_tests = 0;

  dpram_port_ctrl DUT(.core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_addr(mem_addr),
    .mem_rw(mem_rw), .mem_oe_n(mem_oe_n), .mem_data_o(mem_data_o),
    .mem_data_oe(mem_data_oe), .mem_data_i(mem_data_i));
  dpram_mem_model MEM(.addr(mem_addr), .rw(mem_rw), .oe_n(mem_oe_n), .data_oe(mem_data_oe),
    .data_o(mem_data_o), .data_i(mem_data_i), .clash(clash));

  initial forever #5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits for ready under a bound, then offers one request for one edge
  task automatic op(input logic w, input logic k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    @(posedge core_clk);
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(posedge core_clk);
    if (i == 40) n_mismatch++;
    req_valid <= 1'b1;
    req <= '{write: w, keep_oe_low: k, addr: a, wdata: d};
    @(posedge core_clk);
    req_valid <= 1'b0;
    if (!w) expq.push_back(d);
  endtask

  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      check(expq.size() > 0, 1);
      if (expq.size() > 0) check(rsp_data, expq.pop_front());
    end
  end

  // Pin watcher: address moves, pulse lengths, bus contention
  always @(posedge core_clk) begin
    if (!srst) begin
      if (mem_addr !== pa) check({mem_rw, prw}, 2'b11);
      check(clash, 0);
      if (mem_oe_n === 1'b0 && po && expq.size() > 0) check(mem_addr, pa);
      if (mem_rw === 1'b0) begin
        wl <= wl + 4'h1;
        ol <= !mem_oe_n;
      end else if (wl != 4'h0) begin
        check(wl >= (ol ? WP_LO_CNT : WP_HI_CNT), 1);
        check(pdoe, 1);
        wl <= 4'h0;
      end
    end
    pa <= mem_addr;
    prw <= mem_rw;
    po <= mem_oe_n;
    pdoe <= mem_data_oe;
  end

  initial begin
    #50000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    int k;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    op(1, 0, 12'h000, 9'h1ff);
    op(1, 1, 12'hfff, 9'h100);
    op(0, 0, 12'h000, 9'h1ff);
    op(0, 1, 12'hfff, 9'h100);
    for (k = 0; k < 30; k++) begin
      rng = xs(rng);
      op(1, rng[21], rng[11:0], rng[20:12]);
      op(0, rng[22], rng[11:0], rng[20:12]);
    end
    repeat (12) @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    // Last word written must survive a controller reset
    op(0, 0, rng[11:0], rng[20:12]);
    repeat (12) @(posedge core_clk);
    check(expq.size(), 0);
    end_sim;
  end
endmodule
`default_nettype wire
